// ===== pcx_regs.vh
// Function
// - Non-analog pins serve peripheral or general I/O
// - Routed functions land on unskipped P0.0-P4.7
// - Enabled serial port always on P0.4/P0.5
// - Enabled area-network port fixed P0.6/P0.7
// - Port 4 has no skip mask
// - Pin events raise interrupt or wake request
// - Events work on skipped and claimed pins
// - Analog pins never produce pin events
// - Fixed priority order, serial port first
// - Each non-fixed function gets lowest free pin
// - Claimed pins passed over by later functions
// - Skipped pins treated as already assigned
// - Pins float with pull-ups until enable
// - Analog pins: no driver or receiver, read 0; no pull-up once enabled
`ifndef PCX_REGS_VH
`define PCX_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PCX_OFF_FSEL_A 8'h00
`define PCX_OFF_FSEL_B 8'h04
`define PCX_OFF_FSEL_C 8'h08
`define PCX_OFF_SKIP 8'h0C
`define PCX_OFF_INMODE_LO 8'h10
`define PCX_OFF_INMODE_HI 8'h14
`define PCX_OFF_GPIO_LO 8'h18
`define PCX_OFF_GPIO_HI 8'h1C
`define PCX_OFF_PADS_LO 8'h20
`define PCX_OFF_PADS_HI 8'h24
`define PCX_OFF_MMASK 8'h28
`define PCX_OFF_MVAL 8'h2C
`define PCX_OFF_EXTCFG 8'h30
`define PCX_OFF_CLAIM_LO 8'h34
`define PCX_OFF_CLAIM_HI 8'h38

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCX_A_UART 0
`define PCX_A_SPI 1
`define PCX_A_SMB 2
`define PCX_A_CP0 3
`define PCX_A_CP0A 4
`define PCX_A_CP1 5
`define PCX_A_CP1A 6
`define PCX_A_SYSCLK 7
`define PCX_B_CEX_LSB 0
`define PCX_B_CEX_MSB 2
`define PCX_B_ECI 3
`define PCX_B_T0 4
`define PCX_B_T1 5
`define PCX_C_CAN 0
`define PCX_C_LIN 1
`define PCX_C_XBAR_EN 6
`define PCX_E0_SEL_LSB 0
`define PCX_E0_SEL_MSB 2
`define PCX_E0_POL 3
`define PCX_E1_SEL_LSB 4
`define PCX_E1_SEL_MSB 6
`define PCX_E1_POL 7
`define PCX_E0_EDGE 8
`define PCX_E1_EDGE 9

// ----------------------------------------
// Fixed pins and reset values
// ----------------------------------------
`define PCX_PIN_UART_TX 6'd4
`define PCX_PIN_UART_RX 6'd5
`define PCX_PIN_CAN_TX 6'd6
`define PCX_PIN_CAN_RX 6'd7
`define PCX_EXT_PORT_LSB 6'd8
`define PCX_RST_FSEL 8'h00
`define PCX_RST_SKIP 32'h00000000
`define PCX_RST_INMODE_LO 32'hFFFFFFFF
`define PCX_RST_INMODE_HI 8'hFF
`define PCX_RST_GPIO_LO 32'hFFFFFFFF
`define PCX_RST_GPIO_HI 8'hFF
`define PCX_RST_MATCH 32'h00000000
`define PCX_RST_EXTCFG 10'h000

`endif

// ===== pcx_event.v
`timescale 1ns/1ps
`include "pcx_regs.vh"

module pcx_event (
  input wire pclk,
  input wire presetn,
  input wire [39:0] pad_level,
  input wire [39:0] digital,
  input wire [31:0] match_mask,
  input wire [31:0] match_value,
  input wire [9:0] ext_cfg,
  output reg irq_ext0,
  output reg irq_ext1,
  output reg port_match,
  output reg wake_req
);

  // Active level of one external interrupt line taken from a port 1 pin.
  function ext_active;
    input [2:0] sel;
    input pol;
    input [39:0] pads;
    input [39:0] dig;
    reg [5:0] idx;
    begin
      idx = `PCX_EXT_PORT_LSB + {3'b000, sel};
      ext_active = dig[idx] & (pads[idx] == pol);
    end
  endfunction

  wire act0;
  wire act1;
  wire next_match;
  reg act0_d;
  reg act1_d;
  wire next_e0;
  wire next_e1;

  // Analog pins are masked out of each comparison result.
  assign act0 = ext_active(ext_cfg[`PCX_E0_SEL_MSB:`PCX_E0_SEL_LSB], ext_cfg[`PCX_E0_POL],
    pad_level, digital);
  assign act1 = ext_active(ext_cfg[`PCX_E1_SEL_MSB:`PCX_E1_SEL_LSB], ext_cfg[`PCX_E1_POL],
    pad_level, digital);
  assign next_match = |((pad_level[31:0] ^ match_value) & match_mask & digital[31:0]);
  assign next_e0 = ext_cfg[`PCX_E0_EDGE] ? (act0 & ~act0_d) : act0;
  assign next_e1 = ext_cfg[`PCX_E1_EDGE] ? (act1 & ~act1_d) : act1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act0_d <= 1'b0;
      act1_d <= 1'b0;
      irq_ext0 <= 1'b0;
      irq_ext1 <= 1'b0;
      port_match <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      act0_d <= act0;
      act1_d <= act1;
      irq_ext0 <= next_e0;
      irq_ext1 <= next_e1;
      port_match <= next_match;
      wake_req <= next_e0 | next_e1 | next_match;
    end
  end

endmodule

// ===== pcx_crossbar.v
`timescale 1ns/1ps
`include "pcx_regs.vh"

module pcx_crossbar #(
  parameter NPIN = 40,
  parameter NF = 26
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NF-1:0] func_out,
  input wire [NF-1:0] func_oe,
  output reg [NF-1:0] func_in,
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out,
  output reg [NPIN-1:0] pin_oe,
  output reg [NPIN-1:0] pin_pullup,
  output reg irq_ext0,
  output reg irq_ext1,
  output reg port_match,
  output reg wake_req
);

  // ----------------------------------------
  // Function indices in priority order
  // ----------------------------------------
  localparam [4:0] F_UART_TX = 5'd0;
  localparam [4:0] F_UART_RX = 5'd1;
  localparam [4:0] F_CAN_TX = 5'd2;
  localparam [4:0] F_CAN_RX = 5'd3;
  localparam [4:0] F_LIN_TX = 5'd4;
  localparam [4:0] F_LIN_RX = 5'd5;
  localparam [4:0] F_SPI_SCK = 5'd6;
  localparam [4:0] F_SPI_NSS = 5'd9;
  localparam [4:0] F_SMB_SDA = 5'd10;
  localparam [4:0] F_SMB_SCL = 5'd11;
  localparam [4:0] F_CP0 = 5'd12;
  localparam [4:0] F_CP0A = 5'd13;
  localparam [4:0] F_CP1 = 5'd14;
  localparam [4:0] F_CP1A = 5'd15;
  localparam [4:0] F_SYSCLK = 5'd16;
  localparam [4:0] F_CEX0 = 5'd17;
  localparam [4:0] F_ECI = 5'd23;
  localparam [4:0] F_T0 = 5'd24;
  localparam [4:0] F_T1 = 5'd25;
  localparam [4:0] F_FIRST_FREE = 5'd4;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] function_select_reg_a;
  reg [7:0] function_select_reg_b;
  reg [7:0] function_select_reg_c;
  reg [31:0] pin_skip_mask;
  reg [39:0] pin_input_mode;
  reg [39:0] gpio_latch;
  reg [31:0] port_match_mask;
  reg [31:0] port_match_value;
  reg [9:0] ext_interrupt_pin_config;

  wire crossbar_global_enable;
  wire wr_en;
  wire setup;

  assign crossbar_global_enable = function_select_reg_c[`PCX_C_XBAR_EN];
  assign setup = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  reg [NPIN-1:0] sync1;
  reg [NPIN-1:0] sync2;
  reg [NPIN-1:0] sync3;
  reg [NPIN-1:0] pad_filt;
  wire [NPIN-1:0] pad_level;
  wire [NPIN-1:0] differ;

  assign differ = sync2 ^ sync3;
  // Analog pins have their receiver off and always read as zero.
  assign pad_level = pad_filt & pin_input_mode;

  // Pads idle high on their pull-ups, so the chain starts high to avoid a false edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= {NPIN{1'b1}};
      sync2 <= {NPIN{1'b1}};
      sync3 <= {NPIN{1'b1}};
      pad_filt <= {NPIN{1'b1}};
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pad_filt <= (sync2 & ~differ) | (pad_filt & differ);
    end
  end

  // ----------------------------------------
  // Function enables
  // ----------------------------------------
  reg [NF-1:0] fen;
  integer k;

  always @* begin
    fen = {NF{1'b0}};
    fen[F_UART_TX] = function_select_reg_a[`PCX_A_UART];
    fen[F_UART_RX] = function_select_reg_a[`PCX_A_UART];
    fen[F_CAN_TX] = function_select_reg_c[`PCX_C_CAN];
    fen[F_CAN_RX] = function_select_reg_c[`PCX_C_CAN];
    fen[F_LIN_TX] = function_select_reg_c[`PCX_C_LIN];
    fen[F_LIN_RX] = function_select_reg_c[`PCX_C_LIN];
    for (k = F_SPI_SCK; k <= F_SPI_NSS; k = k + 1) begin
      fen[k] = function_select_reg_a[`PCX_A_SPI];
    end
    fen[F_SMB_SDA] = function_select_reg_a[`PCX_A_SMB];
    fen[F_SMB_SCL] = function_select_reg_a[`PCX_A_SMB];
    fen[F_CP0] = function_select_reg_a[`PCX_A_CP0];
    fen[F_CP0A] = function_select_reg_a[`PCX_A_CP0A];
    fen[F_CP1] = function_select_reg_a[`PCX_A_CP1];
    fen[F_CP1A] = function_select_reg_a[`PCX_A_CP1A];
    fen[F_SYSCLK] = function_select_reg_a[`PCX_A_SYSCLK];
    // The channel count field enables that many counter channels, up to six.
    for (k = 0; k < 6; k = k + 1) begin
      fen[F_CEX0 + k] = (function_select_reg_b[`PCX_B_CEX_MSB:`PCX_B_CEX_LSB] > k[2:0]);
    end
    fen[F_ECI] = function_select_reg_b[`PCX_B_ECI];
    fen[F_T0] = function_select_reg_b[`PCX_B_T0];
    fen[F_T1] = function_select_reg_b[`PCX_B_T1];
  end

  // ----------------------------------------
  // Priority decoder
  // ----------------------------------------
  reg [4:0] owner_idx [0:NPIN-1];
  reg [NPIN-1:0] owner_vld;
  reg [5:0] fpin [0:NF-1];
  reg [NF-1:0] fpin_vld;
  reg [4:0] next_owner_idx [0:NPIN-1];
  reg [NPIN-1:0] next_owner_vld;
  reg [5:0] next_fpin [0:NF-1];
  reg [NF-1:0] next_fpin_vld;
  reg [NPIN-1:0] taken;
  reg found;
  integer f;
  integer p;
  integer rp;
  integer rf;

  always @* begin
    found = 1'b0;
    // Port 4 has no skip bits, so its pins are never pre-taken.
    taken = {8'h00, pin_skip_mask};
    next_owner_vld = {NPIN{1'b0}};
    next_fpin_vld = {NF{1'b0}};
    for (p = 0; p < NPIN; p = p + 1) begin
      next_owner_idx[p] = 5'd0;
    end
    for (f = 0; f < NF; f = f + 1) begin
      next_fpin[f] = 6'd0;
    end
    // Fixed functions claim their own pins ahead of the search.
    if (fen[F_UART_TX]) begin
      taken[`PCX_PIN_UART_TX] = 1'b1;
      taken[`PCX_PIN_UART_RX] = 1'b1;
      next_owner_vld[`PCX_PIN_UART_TX] = 1'b1;
      next_owner_vld[`PCX_PIN_UART_RX] = 1'b1;
      next_owner_idx[`PCX_PIN_UART_TX] = F_UART_TX;
      next_owner_idx[`PCX_PIN_UART_RX] = F_UART_RX;
      next_fpin[F_UART_TX] = `PCX_PIN_UART_TX;
      next_fpin[F_UART_RX] = `PCX_PIN_UART_RX;
      next_fpin_vld[F_UART_TX] = 1'b1;
      next_fpin_vld[F_UART_RX] = 1'b1;
    end
    if (fen[F_CAN_TX]) begin
      taken[`PCX_PIN_CAN_TX] = 1'b1;
      taken[`PCX_PIN_CAN_RX] = 1'b1;
      next_owner_vld[`PCX_PIN_CAN_TX] = 1'b1;
      next_owner_vld[`PCX_PIN_CAN_RX] = 1'b1;
      next_owner_idx[`PCX_PIN_CAN_TX] = F_CAN_TX;
      next_owner_idx[`PCX_PIN_CAN_RX] = F_CAN_RX;
      next_fpin[F_CAN_TX] = `PCX_PIN_CAN_TX;
      next_fpin[F_CAN_RX] = `PCX_PIN_CAN_RX;
      next_fpin_vld[F_CAN_TX] = 1'b1;
      next_fpin_vld[F_CAN_RX] = 1'b1;
    end
    // Remaining functions, in priority order, take the lowest free pin.
    for (f = F_FIRST_FREE; f < NF; f = f + 1) begin
      found = 1'b0;
      if (fen[f]) begin
        for (p = 0; p < NPIN; p = p + 1) begin
          if (!found && !taken[p]) begin
            found = 1'b1;
            taken[p] = 1'b1;
            next_owner_vld[p] = 1'b1;
            next_owner_idx[p] = f[4:0];
            next_fpin[f] = p[5:0];
            next_fpin_vld[f] = 1'b1;
          end
        end
      end
    end
  end

  // The new map is held in flops and acts from the next cycle on.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner_vld <= {NPIN{1'b0}};
      fpin_vld <= {NF{1'b0}};
      for (rp = 0; rp < NPIN; rp = rp + 1) begin
        owner_idx[rp] <= 5'd0;
      end
      for (rf = 0; rf < NF; rf = rf + 1) begin
        fpin[rf] <= 6'd0;
      end
    end else begin
      owner_vld <= next_owner_vld;
      fpin_vld <= next_fpin_vld;
      for (rp = 0; rp < NPIN; rp = rp + 1) begin
        owner_idx[rp] <= next_owner_idx[rp];
      end
      for (rf = 0; rf < NF; rf = rf + 1) begin
        fpin[rf] <= next_fpin[rf];
      end
    end
  end

  // ----------------------------------------
  // Pad drive and function inputs
  // ----------------------------------------
  reg [NPIN-1:0] next_pin_out;
  reg [NPIN-1:0] next_pin_oe;
  reg [NPIN-1:0] next_pin_pullup;
  reg [NF-1:0] next_func_in;
  integer dp;
  integer df;

  always @* begin
    for (dp = 0; dp < NPIN; dp = dp + 1) begin
      if (!crossbar_global_enable) begin
        next_pin_out[dp] = 1'b0;
        next_pin_oe[dp] = 1'b0;
        next_pin_pullup[dp] = 1'b1;
      end else if (!pin_input_mode[dp]) begin
        next_pin_out[dp] = 1'b0;
        next_pin_oe[dp] = 1'b0;
        next_pin_pullup[dp] = 1'b0;
      end else if (owner_vld[dp]) begin
        next_pin_out[dp] = func_out[owner_idx[dp]];
        next_pin_oe[dp] = func_oe[owner_idx[dp]];
        next_pin_pullup[dp] = ~(func_oe[owner_idx[dp]] & ~func_out[owner_idx[dp]]);
      end else begin
        // Unclaimed pins act as open-drain general I/O.
        next_pin_out[dp] = 1'b0;
        next_pin_oe[dp] = ~gpio_latch[dp];
        next_pin_pullup[dp] = gpio_latch[dp];
      end
    end
    for (df = 0; df < NF; df = df + 1) begin
      if (crossbar_global_enable && fpin_vld[df]) begin
        next_func_in[df] = pad_level[fpin[df]];
      end else begin
        next_func_in[df] = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe <= {NPIN{1'b0}};
      pin_pullup <= {NPIN{1'b1}};
      func_in <= {NF{1'b1}};
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup <= next_pin_pullup;
      func_in <= next_func_in;
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  wire ev_ext0;
  wire ev_ext1;
  wire ev_match;
  wire ev_wake;

  // Events watch digital pins of ports 0 to 3, whether claimed or skipped.
  pcx_event u_event (
    .pclk(pclk),
    .presetn(presetn),
    .pad_level(pad_level),
    .digital(pin_input_mode),
    .match_mask(port_match_mask),
    .match_value(port_match_value),
    .ext_cfg(ext_interrupt_pin_config),
    .irq_ext0(ev_ext0),
    .irq_ext1(ev_ext1),
    .port_match(ev_match),
    .wake_req(ev_wake)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ext0 <= 1'b0;
      irq_ext1 <= 1'b0;
      port_match <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq_ext0 <= ev_ext0;
      irq_ext1 <= ev_ext1;
      port_match <= ev_match;
      wake_req <= ev_wake;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  reg [31:0] next_prdata;
  reg next_err;

  always @* begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `PCX_OFF_FSEL_A: next_prdata = {24'h000000, function_select_reg_a};
      `PCX_OFF_FSEL_B: next_prdata = {24'h000000, function_select_reg_b};
      `PCX_OFF_FSEL_C: next_prdata = {24'h000000, function_select_reg_c};
      `PCX_OFF_SKIP: next_prdata = pin_skip_mask;
      `PCX_OFF_INMODE_LO: next_prdata = pin_input_mode[31:0];
      `PCX_OFF_INMODE_HI: next_prdata = {24'h000000, pin_input_mode[39:32]};
      `PCX_OFF_GPIO_LO: next_prdata = gpio_latch[31:0];
      `PCX_OFF_GPIO_HI: next_prdata = {24'h000000, gpio_latch[39:32]};
      `PCX_OFF_PADS_LO: next_prdata = pad_level[31:0];
      `PCX_OFF_PADS_HI: next_prdata = {24'h000000, pad_level[39:32]};
      `PCX_OFF_MMASK: next_prdata = port_match_mask;
      `PCX_OFF_MVAL: next_prdata = port_match_value;
      `PCX_OFF_EXTCFG: next_prdata = {22'h00000, ext_interrupt_pin_config};
      `PCX_OFF_CLAIM_LO: next_prdata = owner_vld[31:0];
      `PCX_OFF_CLAIM_HI: next_prdata = {24'h000000, owner_vld[39:32]};
      default: next_err = 1'b1;
    endcase
  end

  // One wait state: ready rises on the second access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & next_err;
      prdata <= (setup && !pwrite) ? next_prdata : 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_select_reg_a <= `PCX_RST_FSEL;
      function_select_reg_b <= `PCX_RST_FSEL;
      function_select_reg_c <= `PCX_RST_FSEL;
      pin_skip_mask <= `PCX_RST_SKIP;
      pin_input_mode <= {`PCX_RST_INMODE_HI, `PCX_RST_INMODE_LO};
      gpio_latch <= {`PCX_RST_GPIO_HI, `PCX_RST_GPIO_LO};
      port_match_mask <= `PCX_RST_MATCH;
      port_match_value <= `PCX_RST_MATCH;
      ext_interrupt_pin_config <= `PCX_RST_EXTCFG;
    end else if (wr_en) begin
      case (paddr)
        `PCX_OFF_FSEL_A: function_select_reg_a <= pwdata[7:0];
        `PCX_OFF_FSEL_B: function_select_reg_b <= pwdata[7:0];
        `PCX_OFF_FSEL_C: function_select_reg_c <= pwdata[7:0];
        `PCX_OFF_SKIP: pin_skip_mask <= pwdata;
        `PCX_OFF_INMODE_LO: pin_input_mode[31:0] <= pwdata;
        `PCX_OFF_INMODE_HI: pin_input_mode[39:32] <= pwdata[7:0];
        `PCX_OFF_GPIO_LO: gpio_latch[31:0] <= pwdata;
        `PCX_OFF_GPIO_HI: gpio_latch[39:32] <= pwdata[7:0];
        `PCX_OFF_MMASK: port_match_mask <= pwdata;
        `PCX_OFF_MVAL: port_match_value <= pwdata;
        `PCX_OFF_EXTCFG: ext_interrupt_pin_config <= pwdata[9:0];
        default: function_select_reg_a <= function_select_reg_a;
      endcase
    end
  end

endmodule

// ===== pcx_crossbar_checker.sv
`timescale 1ns/1ps
`include "pcx_regs.vh"
module pcx_crossbar_checker #(
  parameter NPIN = 40,
  parameter NF = 26
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NF-1:0] func_out,
  input wire [NF-1:0] func_oe,
  input wire [NF-1:0] func_in,
  input wire [NPIN-1:0] pin_in,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] pin_pullup,
  input wire irq_ext0,
  input wire irq_ext1,
  input wire port_match,
  input wire wake_req
);
  reg [7:0] fa;
  reg [7:0] fc;
  reg [1:0] settle;
  wire wr_ok = psel && penable && pready && pwrite && !pslverr;
  // Settle reaches 3 once the map has had time to follow the last write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa <= 8'h00;
      fc <= 8'h00;
      settle <= 2'h3;
    end else begin
      if (wr_ok && paddr == `PCX_OFF_FSEL_A)
        fa <= pwdata[7:0];
      if (wr_ok && paddr == `PCX_OFF_FSEL_C)
        fc <= pwdata[7:0];
      if (wr_ok)
        settle <= 2'h0;
      else if (settle != 2'h3)
        settle <= settle + 2'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_after_access;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_after_access: assert property (p_ready_after_access) else $error("pready late");
  property p_err_unmapped;
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > `PCX_OFF_CLAIM_HI);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("pslverr wrong");
  property p_prdata_idle;
    !pready || pwrite |-> prdata == 32'h00000000;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("prdata not zero");
  property p_reset_idle;
    $rose(presetn) |-> pin_oe == {NPIN{1'b0}} && &pin_pullup && &func_in && !pready;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle");
  property p_uart_fixed;
    settle == 2'h3 && fc[6] && fa[0] |-> pin_oe[4] == $past(func_oe[0])
      && (!pin_oe[4] || pin_out[4] == $past(func_out[0]));
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("serial tx not on pin 4");
  property p_can_fixed;
    settle == 2'h3 && fc[6] && fc[0] |-> pin_oe[6] == $past(func_oe[2])
      && (!pin_oe[6] || pin_out[6] == $past(func_out[2]));
  endproperty
  a_can_fixed: assert property (p_can_fixed) else $error("area tx not on pin 6");
  property p_xbar_off;
    settle == 2'h3 && !fc[6] |-> pin_oe == {NPIN{1'b0}} && pin_pullup == {NPIN{1'b1}};
  endproperty
  a_xbar_off: assert property (p_xbar_off) else $error("pins driven while off");
  property p_wake;
    wake_req == (irq_ext0 || irq_ext1 || port_match);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request mismatch");
  c_uart: cover property (settle == 2'h3 && fc[6] && fa[0] && func_oe[0]);
  c_err: cover property (pslverr);
  c_irq: cover property (irq_ext0);
  c_match: cover property (port_match);
endmodule

bind pcx_crossbar pcx_crossbar_checker #(.NPIN(NPIN), .NF(NF)) pcx_crossbar_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .func_out(func_out), .func_oe(func_oe), .func_in(func_in), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .irq_ext0(irq_ext0),
  .irq_ext1(irq_ext1), .port_match(port_match), .wake_req(wake_req)
);

// ===== pcx_pad_model.sv
`timescale 1ns/1ps
module pcx_pad_model #(
  parameter NPIN = 40
) (
  input wire pclk,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] pin_pullup,
  input wire [NPIN-1:0] ext_en,
  input wire [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pin_in
);
  logic [NPIN-1:0] noise = '0;
  // A pad with nobody driving and no pull-up wanders every cycle.
  always @(posedge pclk) begin
    noise <= ~noise;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pin_pullup) | (~pin_oe & ~ext_en & ~pin_pullup & noise);
endmodule

// ===== pcx_crossbar_bench.sv
`timescale 1ns/1ps
`include "pcx_regs.vh"
module pcx_crossbar_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [25:0] func_out = 26'h0000000;
  logic [25:0] func_oe = 26'h0000000;
  logic [39:0] ext_en = 40'h0000000000;
  logic [39:0] ext_val = 40'h0000000000;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [25:0] func_in;
  wire [39:0] pin_in;
  wire [39:0] pin_out;
  wire [39:0] pin_oe;
  wire [39:0] pin_pullup;
  wire irq_ext0;
  wire irq_ext1;
  wire port_match;
  wire wake_req;
  int checked = 0;
  int n_mismatch = 0;
  int cycles = 0;
  int pulses = 0;
  logic last_err;
  logic [31:0] q;
  always #5 pclk = ~pclk;
  pcx_crossbar pcx_crossbar_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .func_out(func_out), .func_oe(func_oe), .func_in(func_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .irq_ext0(irq_ext0),
    .irq_ext1(irq_ext1), .port_match(port_match), .wake_req(wake_req)
  );
  pcx_pad_model pcx_pad_model_i (
    .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );
  task print_verdict;
    $display("Counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pin_oe, 40'h0000000000);
    chk(pin_pullup, 40'hFFFFFFFFFF);
    chk(func_in, 40'h0003FFFFFF);
    rdc(`PCX_OFF_FSEL_C, 32'h00000000);
    rdc(`PCX_OFF_SKIP, 32'h00000000);
    rdc(`PCX_OFF_INMODE_LO, 32'hFFFFFFFF);
    rdc(`PCX_OFF_INMODE_HI, 32'h000000FF);
    rdc(8'h3C, 32'h00000000);
    chk(last_err, 40'h0000000001);
    $display("test reset done");
    func_oe <= 26'h0000140;
    func_out <= 26'h0000100;
    ext_en <= 40'h0000000002;
    wr(`PCX_OFF_FSEL_C, 32'h00000040);
    wr(`PCX_OFF_FSEL_A, 32'h00000002);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_LO, 32'h0000000F);
    chk(pin_oe[3:0], 40'h0000000005);
    chk(pin_out[2], 40'h0000000001);
    repeat (8) @(posedge pclk);
    chk(func_in[7], 40'h0000000000);
    $display("test lowest pin done");
    func_oe <= 26'h0000141;
    wr(`PCX_OFF_FSEL_A, 32'h00000003);
    wr(`PCX_OFF_SKIP, 32'h00000002);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_LO, 32'h0000007D);
    chk(pin_oe[4], 40'h0000000001);
    chk(pin_oe[3:0], 40'h0000000009);
    $display("test skip done");
    func_oe <= 26'h0000145;
    wr(`PCX_OFF_FSEL_C, 32'h00000041);
    wr(`PCX_OFF_SKIP, 32'h00000010);
    wr(`PCX_OFF_FSEL_A, 32'h00000007);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_LO, 32'h000003FF);
    chk(pin_oe[7:4], 40'h0000000005);
    wr(`PCX_OFF_FSEL_C, 32'h00000043);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_LO, 32'h00000FFF);
    chk(pin_oe[3:0], 40'h0000000004);
    $display("test priority done");
    ext_en <= 40'h0000000000;
    wr(`PCX_OFF_FSEL_C, 32'h00000040);
    wr(`PCX_OFF_SKIP, 32'hFFFFFFFF);
    wr(`PCX_OFF_FSEL_A, 32'h00000002);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_HI, 32'h0000000F);
    rdc(`PCX_OFF_CLAIM_LO, 32'h00000000);
    chk(pin_oe[35:32], 40'h0000000005);
    wr(`PCX_OFF_FSEL_B, 32'h00000006);
    repeat (3) @(posedge pclk);
    rdc(`PCX_OFF_CLAIM_HI, 32'h000000FF);
    wr(`PCX_OFF_FSEL_C, 32'h00000000);
    repeat (3) @(posedge pclk);
    chk(pin_oe, 40'h0000000000);
    chk(pin_pullup, 40'hFFFFFFFFFF);
    $display("test port four and disable done");
    func_oe <= 26'h0000000;
    ext_en <= 40'h0000000C00;
    wr(`PCX_OFF_SKIP, 32'h00000400);
    wr(`PCX_OFF_FSEL_B, 32'h0000000E);
    wr(`PCX_OFF_FSEL_C, 32'h00000040);
    wr(`PCX_OFF_EXTCFG, 32'h000002AB);
    repeat (12) @(posedge pclk);
    chk(irq_ext0, 40'h0000000000);
    ext_val <= 40'h0000000C00;
    repeat (14) begin
      @(posedge pclk);
      if (irq_ext1 === 1'b1)
        pulses++;
    end
    chk(pulses, 40'h0000000001);
    chk(irq_ext0, 40'h0000000001);
    chk(wake_req, 40'h0000000001);
    wr(`PCX_OFF_MMASK, 32'h00000001);
    repeat (10) @(posedge pclk);
    chk(port_match, 40'h0000000001);
    wr(`PCX_OFF_INMODE_LO, 32'hFFFFF7FF);
    repeat (10) @(posedge pclk);
    chk(irq_ext0, 40'h0000000000);
    chk(pin_pullup[11], 40'h0000000000);
    apb(1'b0, `PCX_OFF_PADS_LO, 32'h00000000, q);
    chk(q[11:10], 40'h0000000001);
    $display("test events done");
    print_verdict();
  end
endmodule
